// ### hdl/bcr_pkg.sv
package bcr_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h60;
    localparam logic [7:0] OFS_EVT_DIS = 8'h64;
    localparam logic [7:0] OFS_CLK_ERR = 8'h68;
    localparam logic [7:0] OFS_CLOCK_STOP_CONTROL = 8'h6C;

    // clock gating field layout
    localparam int SLOT_N = 4;
    localparam int CLK_N = 5;
    localparam int FLD_W = 2;
    localparam int DEV_CLK_BIT = 8;
    localparam int CG_W = 9;
    localparam logic [1:0] SLOT_OFF_CODE = 2'h3;
    localparam logic [CG_W-1:0] CG_RST = 9'h000;
    localparam int RSV_ONES_LSB = 9;
    localparam logic [4:0] RSV_ONES_VAL = 5'h1F;

    // error cause flags, bits 23:16
    localparam int ERR_LSB = 16;
    localparam int ERR_N = 8;
    localparam logic [ERR_N-1:0] ERR_RST = 8'h00;
    // causes that own a disable bit in the event disable register
    localparam logic [ERR_N-1:0] DIS_MASK = 8'h7E;
    localparam logic [ERR_N-1:0] DIS_RST = 8'h00;

    // clock-run control, bits 28:24
    localparam int STOP_STAT_BIT = 24;
    localparam int CR_LSB = 25;
    localparam int CR_W = 4;
    localparam int CR_SEC_EN = 0;
    localparam int CR_PRI_KEEP = 1;
    localparam int CR_PRI_EN = 2;
    localparam int CR_MODE = 3;
    localparam logic [CR_W-1:0] CR_RST = 4'h0;

    // command register: error line enable
    localparam int CMD_SERR_EN_BIT = 0;
    localparam logic CMD_RST = 1'b0;

    // ahb encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [31:0] RDATA_RST = 32'h0000_0000;
endpackage

// ### hdl/bcr_top.sv
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/100ps

module bcr_top
    import bcr_pkg::*;
(
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic HSEL_I,
    input wire logic [31:0] HADDR_I,
    input wire logic [1:0] HTRANS_I,
    input wire logic HWRITE_I,
    input wire logic [2:0] HSIZE_I,
    input wire logic [31:0] HWDATA_I,
    input wire logic HREADY_I,
    output logic HREADYOUT_O,
    output logic HRESP_O,
    output logic [31:0] HRDATA_O,
    input wire logic SEC_CLK_I,
    input wire logic PRI_STOP_REQ_I,
    input wire logic SEC_IDLE_I,
    input wire logic PRI_REQ_PEND_I,
    input wire logic [ERR_N-1:0] ERR_EVT_I,
    output logic PRI_SERR_O,
    output logic [CLK_N-1:0] SEC_CLK_O,
    output logic SEC_STOPPED_O,
    output logic SEC_CLOCK_STOP_CONTROL_EN_O,
    output logic PRI_CLOCK_STOP_CONTROL_EN_O,
    output logic PRI_CLK_STOP_OK_O
);

    function automatic logic hit(input logic [31:0] a, input logic [7:0] ofs);
        hit = (a[31:2] == {24'h00_0000, ofs[7:2]});
    endfunction

    logic [CG_W-1:0] cg_q;
    logic [ERR_N-1:0] flags_q;
    logic [ERR_N-1:0] dis_q;
    logic [CR_W-1:0] cr_q;
    logic serr_en_q;
    logic stopped_q;
    logic [CLK_N-1:0] gate_q;
    logic [CLK_N-1:0] out_q;
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic serr_q;
    logic [31:0] waddr_q;
    logic wr_q;
    logic [31:0] raddr_q;
    logic rd_pend_q;
    logic [31:0] rdata_q;
    logic act;
    logic wr_clkerr;
    logic [ERR_N-1:0] raise;
    logic [ERR_N-1:0] clr;
    logic stop_req;
    logic [CLK_N-1:0] en_raw;
    logic [31:0] rd_word;

    // ahb-lite slave: writes complete with no wait, reads take one wait state
    assign act = HSEL_I && HREADY_I && HTRANS_I[1];

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            wr_q <= 1'b0;
            waddr_q <= 32'h0000_0000;
        end
        else
        begin
            wr_q <= act && HWRITE_I;
            if (act && HWRITE_I)
            begin
                waddr_q <= HADDR_I;
            end
        end
    end

    // read data is sampled one cycle late so a write just before is seen
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            rd_pend_q <= 1'b0;
            raddr_q <= 32'h0000_0000;
            rdata_q <= RDATA_RST;
        end
        else
        begin
            rd_pend_q <= act && !HWRITE_I;
            if (act && !HWRITE_I)
            begin
                raddr_q <= HADDR_I;
            end
            if (rd_pend_q)
            begin
                rdata_q <= rd_word;
            end
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        if (hit(raddr_q, OFS_CLK_ERR))
        begin
            rd_word[CG_W-1:0] = cg_q;
            rd_word[13:RSV_ONES_LSB] = RSV_ONES_VAL;
            rd_word[ERR_LSB+:ERR_N] = flags_q;
        end
        else if (hit(raddr_q, OFS_CLOCK_STOP_CONTROL))
        begin
            rd_word[STOP_STAT_BIT] = stopped_q;
            rd_word[CR_LSB+:CR_W] = cr_q;
        end
        else if (hit(raddr_q, OFS_EVT_DIS))
        begin
            rd_word[ERR_N-1:0] = dis_q;
        end
        else if (hit(raddr_q, OFS_CMD))
        begin
            rd_word[CMD_SERR_EN_BIT] = serr_en_q;
        end
    end

    assign HREADYOUT_O = !rd_pend_q;
    assign HRESP_O = 1'b0;
    assign HRDATA_O = rdata_q;

    // sub-word writes are treated as whole-word writes
    assign wr_clkerr = wr_q && hit(waddr_q, OFS_CLK_ERR);

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            cg_q <= CG_RST;
        end
        else if (wr_clkerr)
        begin
            cg_q <= HWDATA_I[CG_W-1:0];
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            cr_q <= CR_RST;
        end
        else if (wr_q && hit(waddr_q, OFS_CLOCK_STOP_CONTROL))
        begin
            cr_q <= HWDATA_I[CR_LSB+:CR_W];
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            dis_q <= DIS_RST;
            serr_en_q <= CMD_RST;
        end
        else
        begin
            if (wr_q && hit(waddr_q, OFS_EVT_DIS))
            begin
                dis_q <= HWDATA_I[ERR_N-1:0] & DIS_MASK;
            end
            if (wr_q && hit(waddr_q, OFS_CMD))
            begin
                serr_en_q <= HWDATA_I[CMD_SERR_EN_BIT];
            end
        end
    end

    // a cause counts only when it actually raises the error line
    assign raise = ERR_EVT_I & ~dis_q & {ERR_N{serr_en_q}};
    assign clr = wr_clkerr ? HWDATA_I[ERR_LSB+:ERR_N] : {ERR_N{1'b0}};

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            flags_q <= ERR_RST;
            serr_q <= 1'b0;
        end
        else
        begin
            // a new event beats a clear in the same cycle
            flags_q <= (flags_q & ~clr) | raise;
            serr_q <= |raise;
        end
    end

    assign PRI_SERR_O = serr_q;

    // secondary clock source is asynchronous; two stages before any use
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
        end
        else
        begin
            sclk_s1_q <= SEC_CLK_I;
            sclk_s2_q <= sclk_s1_q;
        end
    end

    assign stop_req = cr_q[CR_SEC_EN] && (cr_q[CR_MODE] ?
        (SEC_IDLE_I && !PRI_REQ_PEND_I) : PRI_STOP_REQ_I);

    genvar gi;
    generate
        for (gi = 0; gi < SLOT_N; gi++)
        begin : g_slot
            assign en_raw[gi] = (cg_q[FLD_W*gi+:FLD_W] != SLOT_OFF_CODE) && !stop_req;
        end
    endgenerate
    assign en_raw[DEV_CLK_BIT-SLOT_N] = !cg_q[DEV_CLK_BIT] && !stop_req;

    // gates only move while the clock is low, so no pulse gets clipped
    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            gate_q <= {CLK_N{1'b1}};
            stopped_q <= 1'b0;
        end
        else if (!sclk_s2_q)
        begin
            gate_q <= en_raw;
            stopped_q <= stop_req;
        end
    end

    always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            out_q <= {CLK_N{1'b0}};
        end
        else
        begin
            out_q <= gate_q & {CLK_N{sclk_s2_q}};
        end
    end

    assign SEC_CLK_O = out_q;
    assign SEC_STOPPED_O = stopped_q;
    assign SEC_CLOCK_STOP_CONTROL_EN_O = cr_q[CR_SEC_EN];
    assign PRI_CLOCK_STOP_CONTROL_EN_O = cr_q[CR_PRI_EN];
    assign PRI_CLK_STOP_OK_O = stopped_q && !cr_q[CR_PRI_KEEP];

    default clocking cb @(posedge CORE_CLK_I);
    endclocking
    default disable iff (!RST_N_I);

    property p_slot_off;
        (cg_q[1:0] == SLOT_OFF_CODE && !sclk_s2_q) |=> !gate_q[0] ##1 !SEC_CLK_O[0];
    endproperty
    a_slot_off: assert property (p_slot_off)
        else $error("slot 0 clock not stopped for code 11");

    property p_slot_on;
        (cg_q[7:6] == 2'h1 && !stop_req && !sclk_s2_q) |=> gate_q[3];
    endproperty
    a_slot_on: assert property (p_slot_on)
        else $error("slot 3 clock stopped for code 01");

    property p_dev_off;
        (cg_q[DEV_CLK_BIT] && !sclk_s2_q) |=> !gate_q[4] ##1 !SEC_CLK_O[4];
    endproperty
    a_dev_off: assert property (p_dev_off)
        else $error("device clock not stopped");

    property p_no_clip;
        $changed(gate_q) |-> !$past(sclk_s2_q) && !SEC_CLK_O[0];
    endproperty
    a_no_clip: assert property (p_no_clip)
        else $error("clock gate changed while clock high");

    property p_rsv_read;
        (rd_pend_q && hit(raddr_q, OFS_CLK_ERR)) |=> HRDATA_O[15:9] == 7'h1F;
    endproperty
    a_rsv_read: assert property (p_rsv_read)
        else $error("reserved clock bits read wrong");

    property p_addr_par;
        (ERR_EVT_I[0] && serr_en_q) |=> flags_q[0] && PRI_SERR_O;
    endproperty
    a_addr_par: assert property (p_addr_par)
        else $error("address parity flag not set");

    property p_flag_set;
        (raise != 8'h00) |=> ((flags_q & $past(raise)) == $past(raise));
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("error cause flag lost");

    property p_flag_clr;
        (wr_clkerr && HWDATA_I[ERR_LSB+7] && !raise[7]) |=> !flags_q[7];
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("write one did not clear flag");

    property p_gate_line;
        (!serr_en_q || dis_q[1] && ERR_EVT_I == 8'h02) |=> !PRI_SERR_O;
    endproperty
    a_gate_line: assert property (p_gate_line)
        else $error("error line raised while masked");

    property p_cr_read;
        (rd_pend_q && hit(raddr_q, OFS_CLOCK_STOP_CONTROL))
            |=> HRDATA_O[31:29] == 3'h0 && HRDATA_O[24] == $past(stopped_q);
    endproperty
    a_cr_read: assert property (p_cr_read)
        else $error("clock-run register read wrong");

    property p_pri_keep;
        cr_q[CR_PRI_KEEP] |-> !PRI_CLK_STOP_OK_O;
    endproperty
    a_pri_keep: assert property (p_pri_keep)
        else $error("primary clock allowed to stop while kept");

    property p_mode0;
        (!cr_q[CR_MODE] && !PRI_STOP_REQ_I && !sclk_s2_q) |=> !stopped_q;
    endproperty
    a_mode0: assert property (p_mode0)
        else $error("secondary clock stopped without request");

    property p_dev_on;
        (!cg_q[DEV_CLK_BIT] && !stop_req && !sclk_s2_q) |=> gate_q[4];
    endproperty
    a_dev_on: assert property (p_dev_on)
        else $error("device clock stopped while enabled");

    property p_stop_stat;
        (stop_req && !sclk_s2_q) |=> SEC_STOPPED_O;
    endproperty
    a_stop_stat: assert property (p_stop_stat)
        else $error("stop status not set");

    property primary_system_error_line_idle;
        (raise == 8'h00) |=> !PRI_SERR_O;
    endproperty
    a_serr_idle: assert property (primary_system_error_line_idle)
        else $error("error line raised with no cause");

    c_flag: cover property (raise[3] ##1 flags_q[3]);
    c_stop: cover property ($rose(stopped_q));
    c_read: cover property (rd_pend_q && hit(raddr_q, OFS_CLK_ERR));
    c_clr: cover property (wr_clkerr && clr != 8'h00);

endmodule

// ### tb/bcr_far.sv
`timescale 1ns/100ps
module bcr_far
(
    input wire logic clk_i,
    output logic sec_clk_o,
    output logic [7:0] err_evt_o,
    output logic stop_req_o,
    output logic idle_o,
    output logic pend_o
);
    // the secondary bus clock runs free at one eighth of the core clock, its edges on core falling edges
    initial sec_clk_o = 1'b0;
    always #80 sec_clk_o = ~sec_clk_o;
    initial
    begin
        err_evt_o = 8'h00;
        stop_req_o = 1'b0;
        idle_o = 1'b0;
        pend_o = 1'b0;
    end
    // one-cycle cause pulse, launched just after an edge
    task automatic pulse(input int n);
        @(posedge clk_i);
        err_evt_o <= 8'h01 << n;
        @(posedge clk_i);
        err_evt_o <= 8'h00;
    endtask
    task automatic set_bus(input logic req, input logic idle, input logic pend);
        @(posedge clk_i);
        stop_req_o <= req;
        idle_o <= idle;
        pend_o <= pend;
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/100ps
module tb
    import bcr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready, hresp, sec_clk, stop_req, idle, pend;
    logic serr, stopped, sec_en, pri_en, stop_ok;
    logic [31:0] hrdata;
    logic [7:0] err_evt;
    logic [4:0] clk_out;
    int n_mismatch = 0;
    int n_tests = 0;

    always #10 clk = ~clk;

    bcr_far i_far (.clk_i(clk), .sec_clk_o(sec_clk), .err_evt_o(err_evt),
        .stop_req_o(stop_req), .idle_o(idle), .pend_o(pend));

    bcr_top i_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr),
        .HTRANS_I(htrans), .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata),
        .HREADY_I(hready), .HREADYOUT_O(hready), .HRESP_O(hresp), .HRDATA_O(hrdata),
        .SEC_CLK_I(sec_clk), .PRI_STOP_REQ_I(stop_req), .SEC_IDLE_I(idle),
        .PRI_REQ_PEND_I(pend), .ERR_EVT_I(err_evt), .PRI_SERR_O(serr), .SEC_CLK_O(clk_out),
        .SEC_STOPPED_O(stopped), .SEC_CLOCK_STOP_CONTROL_EN_O(sec_en), .PRI_CLOCK_STOP_CONTROL_EN_O(pri_en),
        .PRI_CLK_STOP_OK_O(stop_ok));

    task automatic results();
        $display("tests %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // hready only moves after rising edges, so the falling edge shows what the next edge samples
    task automatic wait_rdy(output logic [31:0] rd);
        logic rdy;
        int k;
        rdy = 1'b0;
        k = 0;
        while (rdy !== 1'b1)
        begin
            @(negedge clk);
            rdy = hready;
            rd = hrdata;
            @(posedge clk);
            k++;
            if (k > 50)
            begin
                chk("hready", 32'h1, 32'h0);
                results();
            end
        end
    endtask

    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= HTRANS_NONSEQ;
        hwrite <= wr;
        wait_rdy(rd);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy(rd);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0000_0000, x);
        chk(name, exp, x);
        chk("response", 32'h0, {31'h0, hresp});
    endtask

    // long settle first: a new gate value only loads in a low phase of the slow clock
    task automatic watch(input logic [4:0] exp);
        logic [4:0] hi;
        hi = 5'h00;
        repeat (24) @(posedge clk);
        repeat (64)
        begin
            @(negedge clk);
            hi = hi | clk_out;
        end
        chk("running clocks", {27'h0, exp}, {27'h0, hi});
    endtask

    task automatic wait_stop(input logic v);
        int k;
        for (k = 0; k < 100 && stopped !== v; k++)
            @(posedge clk);
        chk("stop status", {31'h0, v}, {31'h0, stopped});
        if (stopped !== v)
        begin
            results();
        end
    endtask

    task automatic t_reset();
        rd_chk("gating reset", OFS_CLK_ERR, 32'h0000_3E00);
        rd_chk("clock-run reset", OFS_CLOCK_STOP_CONTROL, 32'h0000_0000);
        rd_chk("unmapped", 8'h70, 32'h0000_0000);
        watch(5'h1F);
    endtask

    task automatic err_case(input int n, input logic exp, input logic [31:0] flags);
        i_far.pulse(n);
        @(negedge clk);
        chk("error line", {31'h0, exp}, {31'h0, serr});
        @(negedge clk);
        chk("error line end", 32'h0, {31'h0, serr});
        @(posedge clk);
        rd_chk("cause flags", OFS_CLK_ERR, flags);
        wr(OFS_CLK_ERR, 32'hFFFF_0000);
        rd_chk("flags cleared", OFS_CLK_ERR, 32'h0000_3E00);
    endtask

    task automatic t_errors();
        int n;
        wr(OFS_CMD, 32'h0000_0001);
        for (n = 0; n < 8; n++)
            err_case(n, 1'b1, 32'h0000_3E00 | (32'h1 << (16 + n)));
        wr(OFS_EVT_DIS, 32'hFFFF_FFFF);
        rd_chk("disable bits", OFS_EVT_DIS, 32'h0000_007E);
        err_case(2, 1'b0, 32'h0000_3E00);
        err_case(7, 1'b1, 32'h0080_3E00);
        wr(OFS_EVT_DIS, 32'h0000_0000);
        wr(OFS_CMD, 32'h0000_0000);
        err_case(0, 1'b0, 32'h0000_3E00);
    endtask

    task automatic gate_case(input logic [31:0] wv, input logic [31:0] rv, input logic [4:0] run);
        wr(OFS_CLK_ERR, wv);
        rd_chk("gating readback", OFS_CLK_ERR, rv);
        watch(run);
    endtask

    task automatic t_gating();
        gate_case(32'hFFFF_FFFF, 32'h0000_3FFF, 5'h00);
        gate_case(32'h0000_00E4, 32'h0000_3EE4, 5'h17);
        gate_case(32'h0000_011B, 32'h0000_3F1B, 5'h0E);
        gate_case(32'h0000_0000, 32'h0000_3E00, 5'h1F);
    endtask

    task automatic t_clock_stop_control();
        i_far.set_bus(1'b0, 1'b1, 1'b0);
        wr(OFS_CLOCK_STOP_CONTROL, 32'hFFFF_FFFF);
        wait_stop(1'b1);
        rd_chk("clock-run all set", OFS_CLOCK_STOP_CONTROL, 32'h1F00_0000);
        chk("clock-run enables", 32'h3, {30'h0, pri_en, sec_en});
        chk("primary stop ok", 32'h0, {31'h0, stop_ok});
        watch(5'h00);
        wr(OFS_CLOCK_STOP_CONTROL, 32'h1200_0000);
        rd_chk("clock-run idle mode", OFS_CLOCK_STOP_CONTROL, 32'h1300_0000);
        chk("primary stop ok", 32'h1, {31'h0, stop_ok});
        chk("primary enable", 32'h0, {31'h0, pri_en});
        i_far.set_bus(1'b0, 1'b1, 1'b1);
        wait_stop(1'b0);
        wr(OFS_CLOCK_STOP_CONTROL, 32'h0200_0000);
        wait_stop(1'b0);
        i_far.set_bus(1'b1, 1'b0, 1'b1);
        wait_stop(1'b1);
        rd_chk("stop on request", OFS_CLOCK_STOP_CONTROL, 32'h0300_0000);
        wr(OFS_CLOCK_STOP_CONTROL, 32'h0000_0000);
        wait_stop(1'b0);
        chk("secondary enable", 32'h0, {31'h0, sec_en});
    endtask

    initial
    begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_errors();
        t_gating();
        t_clock_stop_control();
        results();
    end
endmodule
